//--- hdl/bki_pkg.sv
// bki_pkg: shared constants and types for the brake interlock sequencer
// assumes a 200 MHz control clock and speeds given as unsigned mm/s
package bki_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_PS = 5000;          // 200 MHz
    localparam int TICK_TIME_US = 1000;           // one millisecond tick
    localparam int TICK_CYCLES = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;  // us to ps, then cycles

    ////////////////////////////////////////////////////////////////////////
    // widths and limits
    localparam int MS_W = 16;                     // delay counts in ms
    localparam int SPD_W = 16;                    // speed in mm/s
    localparam int OPT_W = 3;                     // option code width
    localparam logic [15:0] SLOW_SPEED_MMPS = 16'h001E;  // 30 mm/s
    localparam logic [2:0] OPT_FREE_RUN = 3'h0;   // option: no short brake

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] STOP_MS_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_OFF  = 6'h01,    // servo off, de-energized
        ST_ON   = 6'h02,    // servo on, brake released
        ST_STOP = 6'h04,    // servo off while stopped, delay running
        ST_RUN  = 6'h08,    // servo off while moving, delay running
        ST_ERRW = 6'h10,    // error while moving, brake delay running
        ST_FLT  = 6'h20     // error latched, waiting for reset
    } bki_state_t;

    // programmed settings from the parameter store
    typedef struct packed {
        logic [MS_W-1:0] stop_ms;       // stopped brake delay
        logic [MS_W-1:0] run_ms;        // running brake time
        logic [SPD_W-1:0] thr_speed;    // running brake threshold speed
        logic [OPT_W-1:0] disable_opt;  // short brake choice at servo off
        logic [OPT_W-1:0] fault_opt;    // short brake choice at error
    } bki_cfg_t;

    // forced-brake bits from the fieldbus master
    typedef struct packed {
        logic brake_bit;    // 0 release, 1 engage
        logic mask_bit;     // 1 honours brake_bit
    } bki_force_t;

endpackage : bki_pkg

//--- hdl/bki_ms_timer.sv
// bki_ms_timer: millisecond down-counter with its own tick prescaler
// assumes load is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/1ps
`default_nettype none

module bki_ms_timer #(
    parameter int TICK_CYCLES = bki_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [bki_pkg::MS_W-1:0] load_val,
    output logic done
);

    logic [17:0] pre_r;
    logic [bki_pkg::MS_W-1:0] cnt_r;
    wire tick = (pre_r == 18'(TICK_CYCLES - 1));
    wire zero = (cnt_r == '0);

    ////////////////////////////////////////////////////////////////////////
    // prescaler restarts at load so the first ms is a full one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= 18'h00000;
        end else if (load || tick) begin
            pre_r <= 18'h00000;
        end else begin
            pre_r <= pre_r + 18'h00001;
        end
    end

    // down-counter, one step per millisecond
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= bki_pkg::STOP_MS_RST;
        end else if (load) begin
            cnt_r <= load_val;              // [RULE15]
        end else if (tick && !zero) begin
            cnt_r <= cnt_r - 16'h0001;      // [RULE15]
        end
    end

    assign done = zero && !load;

endmodule : bki_ms_timer

`default_nettype wire

//--- hdl/bki_sequencer.sv
// bki_sequencer: holding brake release, short brake and motor power sequencing
// assumes all inputs but main_power_ok come from logic on clk;
// main_power_ok is a pin and is synchronised here
//
// Operation
// RULE1: stopped servo-off waits stop delay, then brakes
// RULE2: moving servo-off brakes at time or slow speed; code brakes below the threshold speed cfg.thr_speed, not at 30 mm/s
// RULE3: master bit 0 releases, 1 engages
// RULE4: forced bit ignored unless mask is 1
// RULE5: release when sequencer or master asks
// RULE6: engage only when both ask engagement
// RULE7: forced engage while servo on warns
// RULE8: servo on only at 30 mm/s or less
// RULE9: servo-on above threshold warns and is discarded
// RULE10: servo-on during deceleration waits for stop
// RULE11: servo-off short brake follows disable option
// RULE12: error short brake follows fault option
// RULE13: main power loss while energized is error
// RULE14: after error reset stay off until servo-on
// RULE15: delays are ms down-counters loaded at event
// RULE16: brake output engages on on, off, error; code releases it in servo on (ST_ON)
`timescale 1ns/1ps
`default_nettype none

module bki_sequencer #(
    parameter int TICK_CYCLES = bki_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire bki_pkg::bki_cfg_t cfg,
    input wire bki_pkg::bki_force_t force_cmd,
    input wire logic servo_on_cmd,
    input wire logic [bki_pkg::SPD_W-1:0] speed_abs,
    input wire logic error_in,
    input wire logic error_reset,
    input wire logic main_power_ok,
    output logic brake_release_output,
    output logic short_circuit_brake,
    output logic motor_power,
    output logic servo_active,
    output logic cmd_warning
);

    ////////////////////////////////////////////////////////////////////////
    // short brake engaged for every option but free run
    function automatic logic db_engage(input logic [bki_pkg::OPT_W-1:0] opt);
        db_engage = (opt != bki_pkg::OPT_FREE_RUN);
    endfunction : db_engage

    ////////////////////////////////////////////////////////////////////////
    // declarations
    bki_pkg::bki_state_t st_r, st_nxt;
    logic pwr_s1_r, pwr_s2_r;
    logic son_q_r, feng_q_r, pend_r, pend_nxt;
    logic warn_nxt, load, tmr_done;
    logic [bki_pkg::MS_W-1:0] load_val;
    logic rel_r, db_r, pwr_r, act_r, warn_r;
    logic master_rel_q;

    ////////////////////////////////////////////////////////////////////////
    // main power pin synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_s1_r <= 1'b0;
            pwr_s2_r <= 1'b0;
        end else begin
            pwr_s1_r <= main_power_ok;
            pwr_s2_r <= pwr_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded conditions
    wire force_eng = force_cmd.mask_bit && force_cmd.brake_bit;      // [RULE3] [RULE4]
    wire master_rel = force_cmd.mask_bit && !force_cmd.brake_bit;    // [RULE3] [RULE4]
    wire son_edge = servo_on_cmd && !son_q_r;
    wire feng_edge = force_eng && !feng_q_r;
    wire is_slow = (speed_abs <= bki_pkg::SLOW_SPEED_MMPS);         // [RULE8]
    wire above_thr = (speed_abs > cfg.thr_speed);
    wire below_thr = (speed_abs < cfg.thr_speed);
    wire power_lost = pwr_r && !pwr_s2_r;                            // [RULE13]
    wire err = error_in || power_lost;                               // [RULE13]
    wire servo_off_state = (st_r == bki_pkg::ST_OFF) || (st_r == bki_pkg::ST_STOP)
                         || (st_r == bki_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // next state, timer load and warnings
    always_comb begin
        st_nxt = st_r;
        pend_nxt = pend_r && servo_on_cmd;
        warn_nxt = 1'b0;
        load = 1'b0;
        load_val = cfg.run_ms;
        if (servo_off_state && son_edge && !err) begin
            if (above_thr) begin
                warn_nxt = 1'b1;                                      // [RULE9]
                pend_nxt = 1'b0;                                      // [RULE9]
            end else begin
                pend_nxt = 1'b1;                                      // [RULE10]
            end
        end
        if (st_r == bki_pkg::ST_ON && feng_edge) begin
            warn_nxt = 1'b1;                                          // [RULE7]
        end
        case (st_r)
            bki_pkg::ST_OFF: begin
                if (pend_r && servo_on_cmd && is_slow && !err) begin
                    st_nxt = bki_pkg::ST_ON;                          // [RULE8] [RULE10]
                    pend_nxt = 1'b0;
                end
            end
            bki_pkg::ST_ON: begin
                if (err && !is_slow) begin
                    st_nxt = bki_pkg::ST_ERRW;                        // [RULE12] [RULE13]
                    load = 1'b1;
                end else if (err) begin
                    st_nxt = bki_pkg::ST_FLT;                         // [RULE16]
                end else if (!servo_on_cmd && is_slow) begin
                    st_nxt = bki_pkg::ST_STOP;                        // [RULE1]
                    load = 1'b1;
                    load_val = cfg.stop_ms;                           // [RULE1] [RULE15]
                end else if (!servo_on_cmd) begin
                    st_nxt = bki_pkg::ST_RUN;                         // [RULE2]
                    load = 1'b1;                                      // [RULE15]
                end
            end
            bki_pkg::ST_STOP: begin
                if (err) begin
                    st_nxt = bki_pkg::ST_FLT;
                end else if (tmr_done) begin
                    st_nxt = bki_pkg::ST_OFF;                         // [RULE1]
                end
            end
            bki_pkg::ST_RUN: begin
                if (err) begin
                    st_nxt = bki_pkg::ST_ERRW;                        // [RULE12]
                    load = 1'b1;
                end else if (tmr_done || below_thr) begin
                    st_nxt = bki_pkg::ST_OFF;                         // [RULE2]
                end
            end
            bki_pkg::ST_ERRW: begin
                if (tmr_done || below_thr) begin
                    st_nxt = bki_pkg::ST_FLT;                         // [RULE2] [RULE16]
                end
            end
            bki_pkg::ST_FLT: begin
                pend_nxt = 1'b0;
                if (error_reset && !err) begin
                    st_nxt = bki_pkg::ST_OFF;                         // [RULE14]
                end
            end
            default: begin
                st_nxt = bki_pkg::ST_FLT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // output decode from the next state
    wire int_rel = (st_nxt == bki_pkg::ST_ON) || (st_nxt == bki_pkg::ST_STOP)
                 || (st_nxt == bki_pkg::ST_RUN) || (st_nxt == bki_pkg::ST_ERRW);
    wire rel_nxt = int_rel || master_rel;                             // [RULE5] [RULE6]
    wire pwr_nxt = (st_nxt == bki_pkg::ST_ON) || (st_nxt == bki_pkg::ST_STOP)
                 || (st_nxt == bki_pkg::ST_RUN);
    wire flt_side = (st_nxt == bki_pkg::ST_ERRW) || (st_nxt == bki_pkg::ST_FLT);
    wire db_nxt = flt_side ? db_engage(cfg.fault_opt)                 // [RULE12]
                : (st_nxt == bki_pkg::ST_OFF) ? db_engage(cfg.disable_opt) : 1'b0; // [RULE11]

    ////////////////////////////////////////////////////////////////////////
    // state and edge registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= bki_pkg::ST_OFF;
            pend_r <= 1'b0;
            son_q_r <= 1'b0;
            feng_q_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pend_r <= pend_nxt;
            son_q_r <= servo_on_cmd;
            feng_q_r <= force_eng;
        end
    end

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rel_r <= 1'b0;
            db_r <= 1'b1;
            pwr_r <= 1'b0;
            act_r <= 1'b0;
            warn_r <= 1'b0;
        end else begin
            rel_r <= rel_nxt;                                         // [RULE5] [RULE6]
            db_r <= db_nxt;
            pwr_r <= pwr_nxt;
            act_r <= (st_nxt == bki_pkg::ST_ON);
            warn_r <= warn_nxt;
        end
    end

    assign brake_release_output = rel_r;
    assign short_circuit_brake = db_r;
    assign motor_power = pwr_r;
    assign servo_active = act_r;
    assign cmd_warning = warn_r;

    ////////////////////////////////////////////////////////////////////////
    // shared millisecond delay timer
    bki_ms_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .load(load),
        .load_val(load_val),
        .done(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_MASTER_RELEASE: assert property (master_rel |=> brake_release_output) // [RULE5]
        else $error("master release request not honoured");
    AST_BOTH_ENGAGE: assert property ( // [RULE6]
        (st_nxt == bki_pkg::ST_OFF && force_eng) |=> !brake_release_output)
        else $error("brake released with both sides asking engagement");
    AST_MASK_IGNORED: assert property ( // [RULE4]
        (!force_cmd.mask_bit && st_nxt == bki_pkg::ST_OFF) |=> !brake_release_output)
        else $error("unmasked forced bit affected the brake");
    AST_FORCE_WARN: assert property ( // [RULE7]
        (st_r == bki_pkg::ST_ON && force_eng && !feng_q_r) |=> cmd_warning ##1 !cmd_warning)
        else $error("no one-cycle warning for forced engage at servo on");
    AST_FAST_ON_WARN: assert property ( // [RULE9]
        (st_r == bki_pkg::ST_OFF && son_edge && above_thr && !err)
        |=> cmd_warning && !servo_active && !pend_r)
        else $error("fast servo-on not warned and discarded");
    AST_ON_SLOW: assert property ( // [RULE8]
        $rose(servo_active) |-> $past(speed_abs) <= bki_pkg::SLOW_SPEED_MMPS)
        else $error("servo on entered above slow speed");
    AST_STOP_HOLD: assert property ( // [RULE1]
        (st_r == bki_pkg::ST_STOP && !tmr_done && !err) |=> brake_release_output && motor_power)
        else $error("brake applied before stopped delay elapsed");
    AST_RUN_SPEED: assert property ( // [RULE2]
        (st_r == bki_pkg::ST_RUN && below_thr && !err) |=> st_r == bki_pkg::ST_OFF
        ##0 (brake_release_output == master_rel_q))
        else $error("running brake not applied at threshold speed");
    AST_ERR_RESET: assert property ( // [RULE14]
        (st_r == bki_pkg::ST_FLT && error_reset && !err) |=> !servo_active [*2])
        else $error("servo energised straight after error reset");
    AST_PWR_LOSS: assert property ( // [RULE13]
        (st_r == bki_pkg::ST_ON && power_lost) |=> !motor_power && !servo_active)
        else $error("main power loss not handled as error");
    AST_DB_OPT: assert property ( // [RULE11]
        (st_nxt == bki_pkg::ST_OFF) |=> short_circuit_brake == $past(db_engage(cfg.disable_opt)))
        else $error("short brake does not follow disable option");

    // fault, power and deceleration paths
    AST_ERR_POWER_OFF: assert property ( // [RULE12]
        (st_r == bki_pkg::ST_ON && err) |=> !motor_power && !servo_active)
        else $error("motor power kept after error");
    AST_DB_FAULT: assert property ( // [RULE12]
        flt_side |=> short_circuit_brake == $past(db_engage(cfg.fault_opt)))
        else $error("short brake does not follow fault option");
    AST_DECEL_OFF: assert property ( // [RULE10]
        (st_r == bki_pkg::ST_RUN) |=> !servo_active)
        else $error("servo on entered during deceleration");
    AST_FLT_ENGAGE: assert property ( // [RULE16]
        (st_r == bki_pkg::ST_FLT && !master_rel) |=> !brake_release_output)
        else $error("brake released in fault without master request");
    AST_ON_RELEASE: assert property ( // [RULE16]
        (st_r == bki_pkg::ST_ON)
        |-> brake_release_output && motor_power && !short_circuit_brake)
        else $error("servo on without released brake and power");
    AST_RUN_TIME: assert property ( // [RULE2]
        (st_r == bki_pkg::ST_RUN && tmr_done && !err) |=> st_r == bki_pkg::ST_OFF)
        else $error("running brake time elapsed without braking");
    AST_OFF_UNPOWERED: assert property ( // [RULE1]
        (st_r == bki_pkg::ST_OFF) |-> !motor_power && !servo_active)
        else $error("motor powered in servo off");
    AST_STOP_END: assert property ( // [RULE1]
        (st_r == bki_pkg::ST_STOP && tmr_done && !err) |=> !motor_power)
        else $error("power kept after stopped delay");
    AST_ERRW_DONE: assert property ( // [RULE2]
        (st_r == bki_pkg::ST_ERRW && below_thr) |=> st_r == bki_pkg::ST_FLT)
        else $error("error deceleration did not end at threshold speed");
    AST_FLT_NO_SERVO: assert property ( // [RULE14]
        (st_r == bki_pkg::ST_FLT) |=> !servo_active)
        else $error("servo energised while error latched");

    // master release one cycle late, for the running brake check
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_rel_q <= 1'b0;
        end else begin
            master_rel_q <= master_rel;
        end
    end

    COV_ON: cover property ($rose(servo_active));
    COV_STOP_OFF: cover property (st_r == bki_pkg::ST_STOP ##1 st_r == bki_pkg::ST_OFF);
    COV_ERR_RUN: cover property (st_r == bki_pkg::ST_ERRW ##1 st_r == bki_pkg::ST_FLT);
    COV_WARN: cover property (cmd_warning);
    COV_DECEL_PEND: cover property (st_r == bki_pkg::ST_RUN && son_edge);

endmodule : bki_sequencer

`default_nettype wire

//--- tb/bki_master_model.sv
// bki_master_model: fieldbus master side that drives the forced-brake bits
// assumes release and engage requests are levels from the bench on clk
`timescale 1ns/1ps
`default_nettype none

module bki_master_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic rel_req,
    input wire logic eng_req,
    output var bki_pkg::bki_force_t force_cmd
);
    // mask up whenever the master asks anything; release beats engage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            force_cmd <= '0;
        end else begin
            force_cmd.mask_bit <= rel_req | eng_req;
            force_cmd.brake_bit <= eng_req & ~rel_req;
        end
    end
endmodule : bki_master_model
`default_nettype wire

//--- tb/test_brake_interlock_sequencer.sv
// test_brake_interlock_sequencer: self-checking bench for bki_sequencer
// assumes bki_pkg and bki_master_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module test_brake_interlock_sequencer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bki_pkg::bki_cfg_t cfg = '{16'h0003, 16'h0064, 16'h0064, 3'h1, 3'h2};
    bki_pkg::bki_force_t force_cmd;
    logic rel_req = 1'b0;
    logic eng_req = 1'b0;
    logic servo_on_cmd = 1'b0;
    logic [15:0] speed_abs = 16'h0000;
    logic error_in = 1'b0;
    logic error_reset = 1'b0;
    logic main_power_ok = 1'b1;
    logic brk, sb, pwr, act, warn;
    logic warn_seen = 1'b0;
    logic [4:0] outs;
    int fail_count = 0;
    int check_count = 0;
    int cyc_count = 0;
    // rows: release, engage, disable option set, brake out, short brake
    localparam logic [4:0] ROWS [5] = '{5'h00, 5'h05, 5'h12, 5'h17, 5'h0D};

    ////////////////////////////////////////
    // clock, design, master
    initial begin
        forever #2.5 clk = ~clk;
    end
    bki_sequencer #(.TICK_CYCLES(4)) dut (
        .clk(clk), .rst(rst), .cfg(cfg), .force_cmd(force_cmd),
        .servo_on_cmd(servo_on_cmd), .speed_abs(speed_abs), .error_in(error_in),
        .error_reset(error_reset), .main_power_ok(main_power_ok),
        .brake_release_output(brk), .short_circuit_brake(sb), .motor_power(pwr),
        .servo_active(act), .cmd_warning(warn)
    );
    bki_master_model master (
        .clk(clk), .rst(rst), .rel_req(rel_req), .eng_req(eng_req), .force_cmd(force_cmd)
    );
    assign outs = {brk, sb, pwr, act, warn};

    // sticky note of warning pulses
    always @(posedge clk) begin
        if (warn === 1'b1) begin
            warn_seen <= 1'b1;
        end
    end
    // hang guard
    always @(posedge clk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 5000) begin
            fail_count++;
            results();
        end
    end

    ////////////////////////////////////////
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    // wait a bounded time for one output to reach a level
    task automatic wait_out(input int idx, input logic exp, input int max, input string msg);
        int k;
        k = 0;
        @(negedge clk);
        while (outs[idx] !== exp && k < max) begin
            @(negedge clk);
            k++;
        end
        chk(outs[idx], exp, msg);
    endtask : wait_out
    // fresh servo-on edge at slow speed
    task automatic servo_up();
        cyc(1);
        servo_on_cmd <= 1'b0;
        cyc(1);
        servo_on_cmd <= 1'b1;
        wait_out(1, 1'b1, 8, "servo on");
    endtask : servo_up
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(brk, 1'b0, "reset brake out");
        chk(sb, 1'b1, "reset short brake");
        chk(pwr | act | warn, 1'b0, "reset power");
        cyc(1);
        rst <= 1'b0;
        $display("test reset done");
        foreach (ROWS[i]) begin
            cyc(1);
            rel_req <= ROWS[i][4];
            eng_req <= ROWS[i][3];
            cfg.disable_opt <= ROWS[i][2] ? 3'h1 : bki_pkg::OPT_FREE_RUN;
            cyc(4);
            @(negedge clk);
            chk(brk, ROWS[i][1], "table brake out");
            chk(sb, ROWS[i][0], "table short brake");
        end
        cyc(1);
        rel_req <= 1'b0;
        eng_req <= 1'b0;
        cfg.disable_opt <= 3'h1;
        $display("test table done");
        servo_up();
        chk(pwr & brk & ~sb, 1'b1, "servo on outputs");
        cyc(1);
        warn_seen <= 1'b0;
        eng_req <= 1'b1;
        cyc(4);
        @(negedge clk);
        chk(warn_seen, 1'b1, "forced engage warning");
        chk(brk, 1'b1, "brake kept released");
        cyc(1);
        eng_req <= 1'b0;
        servo_on_cmd <= 1'b0;
        cyc(8);
        @(negedge clk);
        chk(brk & pwr, 1'b1, "stop delay running");
        wait_out(4, 1'b0, 10, "stop delay end");
        chk(pwr, 1'b0, "power removed");
        chk(sb, 1'b1, "short brake at off");
        $display("test stopped off done");
        cyc(1);
        warn_seen <= 1'b0;
        speed_abs <= 16'h01F4;
        cyc(2);
        servo_on_cmd <= 1'b1;
        cyc(6);
        speed_abs <= 16'h0014;
        @(negedge clk);
        chk(warn_seen, 1'b1, "moving servo on warning");
        cyc(6);
        @(negedge clk);
        chk(act, 1'b0, "request discarded");
        cyc(1);
        servo_on_cmd <= 1'b0;
        speed_abs <= 16'h0032;
        cyc(1);
        servo_on_cmd <= 1'b1;
        cyc(6);
        @(negedge clk);
        chk(act, 1'b0, "waits above slow speed");
        cyc(1);
        speed_abs <= 16'h001E;
        wait_out(1, 1'b1, 6, "on at slow speed");
        $display("test moving on done");
        cyc(1);
        speed_abs <= 16'h00C8;
        cyc(1);
        servo_on_cmd <= 1'b0;
        cyc(30);
        @(negedge clk);
        chk(brk & pwr, 1'b1, "running brake waits");
        cyc(1);
        speed_abs <= 16'h0063;
        wait_out(4, 1'b0, 4, "brake below threshold");
        cyc(1);
        speed_abs <= 16'h0000;
        cfg.run_ms <= 16'h0002;
        servo_up();
        cyc(1);
        speed_abs <= 16'h00C8;
        cyc(1);
        servo_on_cmd <= 1'b0;
        cyc(5);
        @(negedge clk);
        chk(brk, 1'b1, "run time counting");
        wait_out(4, 1'b0, 8, "brake at run time");
        $display("test moving off done");
        cyc(1);
        speed_abs <= 16'h0000;
        servo_up();
        cyc(1);
        speed_abs <= 16'h00C8;
        cyc(1);
        error_in <= 1'b1;
        wait_out(2, 1'b0, 3, "power cut at error");
        chk(brk & sb, 1'b1, "error decel outputs");
        cyc(1);
        speed_abs <= 16'h0010;
        wait_out(4, 1'b0, 4, "brake after error decel");
        cyc(1);
        error_in <= 1'b0;
        error_reset <= 1'b1;
        cyc(1);
        error_reset <= 1'b0;
        cyc(8);
        @(negedge clk);
        chk(act | pwr, 1'b0, "off after error reset");
        servo_up();
        $display("test error done");
        cyc(1);
        main_power_ok <= 1'b0;
        wait_out(2, 1'b0, 6, "power loss is error");
        chk(brk | act, 1'b0, "power loss braking");
        cyc(1);
        main_power_ok <= 1'b1;
        $display("test power loss done");
        cyc(1);
        servo_on_cmd <= 1'b0;
        rst <= 1'b1;
        cyc(2);
        @(negedge clk);
        chk(brk | pwr | act | warn, 1'b0, "mid-run reset outputs");
        chk(sb, 1'b1, "mid-run reset short brake");
        cyc(1);
        rst <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk(brk | pwr | act, 1'b0, "off after reset release");
        chk(sb, 1'b1, "short brake after reset release");
        $display("test mid-run reset done");
        results();
    end
endmodule : test_brake_interlock_sequencer
`default_nettype wire
